// ==== rtl/sync_port_params.svh ====
`ifndef SYNC_PORT_PARAMS_SVH
`define SYNC_PORT_PARAMS_SVH

`define FIFO_WIDTH          16
`define FIFO_DEPTH          8
`define FMT_SPI             2'h0
`define FMT_FRAME_PULSE     2'h1
`define FMT_MESSAGE         2'h2
`define MIN_SIZE_CODE       4'h3
`define MSG_CTRL_BITS       6'h09
`define MSG_RX_FIRST        5'h09
`define LEAD_HALVES         6'h02
`define TIMEOUT_HALF_TICKS  7'h40

`endif

// ==== rtl/sync_port_pkg.sv ====
package sync_port_pkg;

   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_WAIT_END} state_t;

   typedef logic [1:0] format_t;

endpackage

// ==== rtl/sync_port_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sync_port_params.svh"

module sync_port_fifo #(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   ////////////////////////////////////////////////////////////////////////////
   // The slot under the read pointer is shown even when empty. Entries are
   // never erased, so an empty ring shows the word written DEPTH writes ago,
   // or zero if fewer writes have happened since reset.
   assign out_data = mem[rd_ptr];

   always_comb
   begin
      push        = in_valid && in_ready;
      pop         = out_ready && out_valid;
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push)
      begin
         next_mem[wr_ptr] = in_data;
         next_wr_ptr      = AW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
         next_rd_ptr = AW'(rd_ptr + 1'b1);
      end
      next_count = (AW+1)'(count + push - pop);
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end
      else
      begin
         mem       <= next_mem;
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end

endmodule
`default_nettype wire

// ==== rtl/sync_serial_port.sv ====
// Function
// - Runs as clock master or follower slave.
// - Separate eight-word sixteen-bit transmit and receive queues.
// - Word length programmable four to sixteen.
// - Loopback routes transmit bit into receiver.
// - Three selectable formats: four-wire, message, pulse.
// - Even prescale divide, two through 254.
// - Second divide by one plus rate.
// - Bit rate is clock over product.
// - Data port write pushes transmit queue.
// - Words leave queue before being shifted.
// - Slave shifts a word every transaction.
// - Empty slave queue resends eighth-latest word.
// - Fewer than eight writes: send zero.
// - Transmit empty raises interrupt or request.
// - Received words wait; each read pops.
// - Shift register assembles word before queue.
// - Most significant bit goes first.
// - All interrupt sources ORed to one.
// - Timeout when idle with data waiting.
`timescale 1ns/1ps
`default_nettype none
`include "sync_port_params.svh"

module sync_serial_port
   import sync_port_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        port_enable,
   input  wire logic        master_mode,
   input  wire logic        loopback,
   input  wire format_t     frame_format,
   input  wire logic        clock_polarity,
   input  wire logic        clock_phase,
   input  wire logic [3:0]  data_size,
   input  wire logic [7:0]  prescale_divisor,
   input  wire logic [7:0]  clock_rate_field,
   input  wire logic        tx_empty_irq_en,
   input  wire logic        tx_empty_dma_en,
   input  wire logic        rx_avail_irq_en,
   input  wire logic        rx_timeout_irq_en,
   input  wire logic        data_port_wr_valid,
   input  wire logic [15:0] data_port_wr_data,
   output var  logic        data_port_wr_ready,
   input  wire logic        data_port_rd_pop,
   output var  logic        data_port_rd_valid,
   output      logic [15:0] data_port_rd_data,
   input  wire logic        serial_clock_in,
   output var  logic        serial_clock_out,
   output var  logic        serial_clock_oe,
   input  wire logic        frame_select_in,
   output var  logic        frame_select_out,
   output var  logic        frame_select_oe,
   input  wire logic        serial_input_pin,
   output var  logic        serial_output_pin,
   output var  logic        serial_output_oe,
   output var  logic        interrupt_request,
   output var  logic        tx_dma_request,
   output var  logic        rx_timeout
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: bit 2 clock, bit 1 frame, bit 0 data.
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_f;
   logic [2:0] next_pin_f;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_filt
         assign next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         // All stages start with the frame input high, its idle level outside pulse format, so release of reset
         // cannot show a false falling edge on the frame input except in pulse format, where the frame idles low.
         pin_s1 <= 3'h2;
         pin_s2 <= 3'h2;
         pin_s3 <= 3'h2;
         pin_f  <= 3'h2;
      end
      else
      begin
         pin_s1 <= {serial_clock_in, frame_select_in, serial_input_pin};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f  <= next_pin_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit-rate divider: a half-bit tick every (prescale/2)*(1+rate) cycles.
   // The low prescale bit is ignored so the divisor is always even.
   logic [6:0] pre_half;
   logic [6:0] pre_cnt;
   logic [6:0] next_pre_cnt;
   logic [7:0] rate_cnt;
   logic [7:0] next_rate_cnt;
   logic       half_tick;

   always_comb
   begin
      pre_half      = (prescale_divisor[7:1] == 7'h00) ? 7'h01 : prescale_divisor[7:1];
      half_tick     = (pre_cnt >= 7'(pre_half - 7'h01)) && (rate_cnt >= clock_rate_field);
      next_pre_cnt  = 7'(pre_cnt + 7'h01);
      next_rate_cnt = rate_cnt;
      if (pre_cnt >= 7'(pre_half - 7'h01))
      begin
         next_pre_cnt  = 7'h00;
         next_rate_cnt = (rate_cnt >= clock_rate_field) ? 8'h00 : 8'(rate_cnt + 8'h01);
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pre_cnt  <= 7'h00;
         rate_cnt <= 8'h00;
      end
      else
      begin
         pre_cnt  <= next_pre_cnt;
         rate_cnt <= next_rate_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Queues.
   logic        tx_valid;
   logic        tx_pop;
   logic [15:0] tx_word;
   logic        rx_push;
   logic [15:0] rx_word;
   logic        rx_ready;

   sync_port_fifo u_tx_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (data_port_wr_valid),
      .in_ready  (data_port_wr_ready),
      .in_data   (data_port_wr_data),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_word)
   );

   sync_port_fifo u_rx_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (rx_push),
      .in_ready  (rx_ready),
      .in_data   (rx_word),
      .out_valid (data_port_rd_valid),
      .out_ready (data_port_rd_pop),
      .out_data  (data_port_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine shared by both roles.
   state_t      state;
   state_t      next_state;
   logic [5:0]  edges;
   logic [5:0]  next_edges;
   logic [15:0] tx_sh;
   logic [15:0] next_tx_sh;
   logic [15:0] rx_sh;
   logic [15:0] next_rx_sh;
   logic        clk_prev;
   logic        fss_prev;
   logic [6:0]  idle_cnt;
   logic [6:0]  next_idle_cnt;
   logic        next_clk_out;
   logic        next_fss_out;
   logic        next_tx_bit;
   logic        is_msg;
   logic        is_pulse;
   logic [4:0]  n_bits;
   logic [5:0]  total_bits;
   logic [4:0]  rx_first;
   logic        sph_eff;
   logic        idle_clk;
   logic        idle_fss;
   logic [15:0] word_left;
   logic        rx_bit;
   logic        edge_evt;
   logic        last_edge;
   logic        capture;
   logic        start;

   always_comb
   begin
      is_msg     = (frame_format == `FMT_MESSAGE);
      is_pulse   = (frame_format == `FMT_FRAME_PULSE);
      n_bits     = 5'((data_size < `MIN_SIZE_CODE) ? `MIN_SIZE_CODE : data_size) + 5'h01;
      total_bits = is_msg ? 6'({1'b0, n_bits} + `MSG_CTRL_BITS) : {1'b0, n_bits};
      rx_first   = is_msg ? `MSG_RX_FIRST : 5'h00;
      sph_eff    = is_msg ? 1'b0 : (is_pulse ? master_mode : clock_phase);
      idle_clk   = (is_msg || is_pulse) ? 1'b0 : clock_polarity;
      idle_fss   = !is_pulse;
      // Left-justify so the top bit leaves first; upper bits drop out.
      word_left  = is_msg ? {tx_word[7:0], 8'h00}
                          : 16'(tx_word << (5'd16 - n_bits));
      rx_bit     = loopback ? serial_output_pin : pin_f[0];
      edge_evt   = (state == ST_SHIFT) &&
                   (master_mode ? half_tick : (pin_f[2] != clk_prev));
      last_edge  = (edges == 6'({total_bits, 1'b0} - 7'h01));
      capture    = (!edges[0] ^ sph_eff) && (edges[5:1] >= rx_first);
      start      = port_enable && (master_mode ? tx_valid
                                  : (is_pulse ? (fss_prev && !pin_f[1]) : !pin_f[1]));

      next_state    = state;
      next_edges    = edges;
      next_tx_sh    = tx_sh;
      next_rx_sh    = rx_sh;
      next_clk_out  = serial_clock_out;
      next_fss_out  = frame_select_out;
      next_tx_bit   = serial_output_pin;
      tx_pop        = 1'b0;
      rx_push       = 1'b0;
      next_idle_cnt = idle_cnt;

      case (state)
         ST_IDLE:
         begin
            next_clk_out = idle_clk;
            next_fss_out = idle_fss;
            if (start)
            begin
               tx_pop      = tx_valid;
               next_edges  = 6'h00;
               next_rx_sh  = 16'h0000;
               next_tx_sh  = sph_eff ? word_left : 16'(word_left << 1);
               next_tx_bit = sph_eff ? 1'b0 : word_left[15];
               next_state  = master_mode ? ST_LEAD : ST_SHIFT;
               next_fss_out = is_pulse;
            end
         end
         ST_LEAD:
         begin
            if (half_tick)
            begin
               next_edges = 6'(edges + 6'h01);
               if (is_pulse)
               begin
                  next_clk_out = !serial_clock_out;
               end
               if (edges == 6'(`LEAD_HALVES - 6'h01))
               begin
                  next_edges = 6'h00;
                  next_state = ST_SHIFT;
               end
            end
         end
         ST_SHIFT:
         begin
            if (!master_mode && !is_pulse && pin_f[1])
            begin
               next_state = ST_IDLE;
            end
            else if (edge_evt)
            begin
               next_edges   = 6'(edges + 6'h01);
               next_clk_out = master_mode ? !serial_clock_out : serial_clock_out;
               if (is_pulse && edges == 6'h00)
               begin
                  next_fss_out = 1'b0;
               end
               if (capture)
               begin
                  next_rx_sh = {rx_sh[14:0], rx_bit};
               end
               else
               begin
                  next_tx_bit = tx_sh[15];
                  next_tx_sh  = {tx_sh[14:0], 1'b0};
               end
               if (last_edge)
               begin
                  rx_push    = 1'b1;
                  next_edges = 6'h00;
                  next_state = master_mode ? ST_TRAIL :
                               (is_pulse ? ST_IDLE : ST_WAIT_END);
               end
            end
         end
         ST_TRAIL:
         begin
            if (half_tick)
            begin
               next_edges = 6'(edges + 6'h01);
               // Frame goes idle one half tick after the last clock edge, so back-to-back
               // four-wire and message words see it pulse high in between; pulse stays low.
               if (edges == 6'h00)
               begin
                  next_fss_out = idle_fss;
               end
               if (edges == 6'(`LEAD_HALVES - 6'h01))
               begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_WAIT_END:
         begin
            if (pin_f[1])
            begin
               next_state = ST_IDLE;
            end
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase

      if (!port_enable)
      begin
         next_state = ST_IDLE;
      end

      // Timeout counts half ticks only while the line is quiet.
      if (state != ST_IDLE || !data_port_rd_valid)
      begin
         next_idle_cnt = 7'h00;
      end
      else if (half_tick && idle_cnt != `TIMEOUT_HALF_TICKS)
      begin
         next_idle_cnt = 7'(idle_cnt + 7'h01);
      end
   end

   // The whole word is captured including the last bit; upper bits stay zero.
   assign rx_word = next_rx_sh;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         state             <= ST_IDLE;
         edges             <= 6'h00;
         tx_sh             <= 16'h0000;
         rx_sh             <= 16'h0000;
         clk_prev          <= 1'b0;
         fss_prev          <= 1'b1;
         idle_cnt          <= 7'h00;
         serial_clock_out  <= 1'b0;
         serial_clock_oe   <= 1'b0;
         frame_select_out  <= 1'b1;
         frame_select_oe   <= 1'b0;
         serial_output_pin <= 1'b0;
         serial_output_oe  <= 1'b0;
         interrupt_request <= 1'b0;
         tx_dma_request    <= 1'b0;
         rx_timeout        <= 1'b0;
      end
      else
      begin
         state             <= next_state;
         edges             <= next_edges;
         tx_sh             <= next_tx_sh;
         rx_sh             <= next_rx_sh;
         clk_prev          <= pin_f[2];
         fss_prev          <= pin_f[1];
         idle_cnt          <= next_idle_cnt;
         serial_clock_out  <= next_clk_out;
         serial_clock_oe   <= port_enable && master_mode;
         frame_select_out  <= next_fss_out;
         frame_select_oe   <= port_enable && master_mode;
         serial_output_pin <= next_tx_bit;
         serial_output_oe  <= (next_state != ST_IDLE);
         rx_timeout        <= (next_idle_cnt == `TIMEOUT_HALF_TICKS);
         tx_dma_request    <= tx_empty_dma_en && !tx_valid;
         interrupt_request <= (tx_empty_irq_en && !tx_valid) ||
                              (rx_avail_irq_en && data_port_rd_valid) ||
                              (rx_timeout_irq_en && rx_timeout);
      end
   end

endmodule
`default_nettype wire

// ==== tb/sync_serial_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_checker
   import sync_port_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        port_enable,
   input wire logic        master_mode,
   input wire format_t     frame_format,
   input wire logic        clock_polarity,
   input wire logic [3:0]  data_size,
   input wire logic [7:0]  prescale_divisor,
   input wire logic [7:0]  clock_rate_field,
   input wire logic        tx_empty_irq_en,
   input wire logic        tx_empty_dma_en,
   input wire logic        rx_avail_irq_en,
   input wire logic        rx_timeout_irq_en,
   input wire logic        data_port_wr_valid,
   input wire logic        data_port_wr_ready,
   input wire logic        data_port_rd_valid,
   input wire logic [15:0] data_port_rd_data,
   input wire logic        serial_clock_out,
   input wire logic        serial_clock_oe,
   input wire logic        frame_select_out,
   input wire logic        frame_select_oe,
   input wire logic        interrupt_request,
   input wire logic        tx_dma_request,
   input wire logic        rx_timeout
);
   logic        prev_clk;
   logic [15:0] since_chg;
   logic [15:0] next_since;
   logic [15:0] half;

   // Half period in system clocks; a zero prescale field behaves as two.
   assign half = (prescale_divisor[7:1] == 7'h00 ? 16'h0001 : 16'(prescale_divisor[7:1]))
                 * (16'(clock_rate_field) + 16'h0001);

   always_comb
   begin
      next_since = (since_chg == 16'hFFFF) ? since_chg : since_chg + 16'h0001;
      if (serial_clock_out != prev_clk)
         next_since = 16'h0001;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         prev_clk  <= 1'b0;
         since_chg <= 16'hFFFF;
      end
      else
      begin
         prev_clk  <= serial_clock_out;
         since_chg <= next_since;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////////
   // The first edge of a frame follows a long idle, so only edges closer than
   // three half periods are timed.
   a_sclk_half_period: assert property (
      master_mode && frame_format == 2'h0 && serial_clock_out != prev_clk
      && 32'(since_chg) < 3 * 32'(half) |-> since_chg == half)
      else $error("serial clock half period wrong");
   a_sclk_idle_level: assert property (
      master_mode && frame_format == 2'h0 && frame_select_oe && frame_select_out
      && $stable(clock_polarity) |-> serial_clock_out == clock_polarity)
      else $error("serial clock not idle outside frame");
   a_master_drives_pins: assert property (
      $past(port_enable && master_mode) && port_enable && master_mode
      |-> serial_clock_oe && frame_select_oe)
      else $error("master does not drive clock and frame");
   a_slave_releases_pins: assert property (
      !master_mode && $past(!master_mode) |-> !serial_clock_oe && !frame_select_oe)
      else $error("slave drives clock or frame");
   a_full_needs_write: assert property (
      $fell(data_port_wr_ready) |-> $past(data_port_wr_valid))
      else $error("write ready fell without a write");
   a_dma_needs_enable: assert property (
      $past(!tx_empty_dma_en) |-> !tx_dma_request)
      else $error("dma request while disabled");
   a_irq_needs_source: assert property (
      $past(!(tx_empty_irq_en || rx_avail_irq_en || rx_timeout_irq_en)) |-> !interrupt_request)
      else $error("interrupt with no source enabled");
   a_timeout_with_data: assert property (
      $rose(rx_timeout) |-> data_port_rd_valid)
      else $error("timeout with empty receive queue");
   a_short_word_zero: assert property (
      data_port_rd_valid && data_size == 4'h7 |-> data_port_rd_data[15:8] == 8'h00)
      else $error("upper bits of short word not zero");

   c_queue_full: cover property ($fell(data_port_wr_ready));
   c_rx_timeout: cover property ($rose(rx_timeout));
   c_dma_request: cover property ($rose(tx_dma_request));
endmodule
`default_nettype wire

// ==== tb/serial_peer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Eight-bit slave with clock idle low, capture on the rising edge.
module serial_peer_model (
   input wire logic  sclk,
   input wire logic  fss,
   input wire logic  mosi,
   input wire logic  en,
   output var logic  miso
);
   logic [15:0] sh;
   logic [15:0] got;
   logic [7:0]  n;
   logic [15:0] got_q[$];

   initial
   begin
      miso = 1'b0;
      n = 8'h00;
   end
   always @(negedge fss)
      if (en)
      begin
         sh = {8'h5A ^ n, 8'h00};
         miso = sh[15];
         got = 16'h0000;
      end
   always @(posedge sclk)
      if (en && !fss)
         got = {got[14:0], mosi};
   always @(negedge sclk)
      if (en && !fss)
      begin
         sh = sh << 1;
         miso = sh[15];
      end
   // A released line shows the inverse of its last level.
   always @(posedge fss)
      if (en)
      begin
         got_q.push_back(got);
         n = n + 8'h01;
         miso = ~miso;
      end
endmodule
`default_nettype wire

// ==== tb/sync_serial_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_tb_top
   import sync_port_pkg::*;
;
   logic        ref_clk, reset, port_enable, master_mode, loopback, clock_polarity, clock_phase;
   logic        tx_empty_irq_en, tx_empty_dma_en, rx_avail_irq_en, rx_timeout_irq_en;
   logic        data_port_wr_valid, data_port_rd_pop, m_sclk, m_fss, m_mosi;
   logic        data_port_wr_ready, data_port_rd_valid, serial_clock_out, serial_clock_oe;
   logic        frame_select_out, frame_select_oe, serial_output_pin, serial_output_oe;
   logic        interrupt_request, tx_dma_request, rx_timeout, peer_miso;
   format_t     frame_format;
   logic [3:0]  data_size;
   logic [7:0]  prescale_divisor, clock_rate_field;
   logic [15:0] data_port_wr_data, data_port_rd_data;
   int          err_count, cmp_count;
   wire logic   sclk_w = serial_clock_oe ? serial_clock_out : m_sclk;
   wire logic   fss_w = frame_select_oe ? frame_select_out : m_fss;
   wire logic   serial_input_pin = master_mode ? peer_miso : m_mosi;

   sync_serial_port sync_serial_port_inst (.ref_clk, .reset, .port_enable, .master_mode,
      .loopback, .frame_format, .clock_polarity, .clock_phase, .data_size, .prescale_divisor,
      .clock_rate_field, .tx_empty_irq_en, .tx_empty_dma_en, .rx_avail_irq_en,
      .rx_timeout_irq_en, .data_port_wr_valid, .data_port_wr_data, .data_port_wr_ready,
      .data_port_rd_pop, .data_port_rd_valid, .data_port_rd_data, .serial_clock_in(sclk_w),
      .serial_clock_out, .serial_clock_oe, .frame_select_in(fss_w), .frame_select_out,
      .frame_select_oe, .serial_input_pin, .serial_output_pin, .serial_output_oe,
      .interrupt_request, .tx_dma_request, .rx_timeout);
   serial_peer_model serial_peer_model_inst (.sclk(sclk_w), .fss(fss_w),
      .mosi(serial_output_pin), .en(master_mode), .miso(peer_miso));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic await(input int sel);
      int k;
      k = 0;
      while ((sel == 0 ? tx_dma_request : sel == 1 ? rx_timeout : data_port_rd_valid) !== 1'b1
             && k < 4000)
      begin
         tick(1);
         k++;
      end
      check("await", 16'(k == 4000), 16'h0000);
   endtask
   // Back-to-back writes: valid stays up across the run.
   task automatic put_run(input logic [15:0] base, input int n);
      for (int i = 0; i < n; i++)
      begin
         data_port_wr_valid <= 1'b1;
         data_port_wr_data <= base + 16'(i) * 16'h0111;
         tick(1);
      end
      data_port_wr_valid <= 1'b0;
      tick(1);
   endtask
   task automatic pop(input logic [15:0] exp, input logic cmp);
      await(2);
      if (cmp)
         check("rd_data", data_port_rd_data, exp);
      data_port_rd_pop <= 1'b1;
      tick(1);
      data_port_rd_pop <= 1'b0;
      tick(1);
   endtask
   // Acts as master toward the slave port; period of 16 clocks respects the slave limit.
   task automatic sframe(input logic [7:0] exp);
      logic [7:0] got;
      got = 8'h00;
      m_fss <= 1'b0;
      tick(8);
      check("tx oe", 16'(serial_output_oe), 16'h0001);
      for (int b = 0; b < 8; b++)
      begin
         got = {got[6:0], serial_output_pin};
         m_mosi <= b[0];
         m_sclk <= 1'b1;
         tick(8);
         m_sclk <= 1'b0;
         tick(8);
      end
      m_fss <= 1'b1;
      m_mosi <= ~m_mosi;
      tick(16);
      check("slave tx", {8'h00, got}, {8'h00, exp});
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      tick(20000);
      err_count++;
      results();
   end
   initial
   begin
      {reset, m_fss} = 2'b11;
      {port_enable, master_mode, loopback, clock_polarity, clock_phase, m_sclk, m_mosi} = 7'h00;
      {tx_empty_irq_en, tx_empty_dma_en, rx_avail_irq_en, rx_timeout_irq_en} = 4'h0;
      {data_port_wr_valid, data_port_rd_pop} = 2'b00;
      frame_format = 2'h0;
      data_size = 4'h7;
      prescale_divisor = 8'h06;
      clock_rate_field = 8'h01;
      data_port_wr_data = 16'h0000;
      {err_count, cmp_count} = 0;
      tick(20);
      reset <= 1'b0;
      tick(1);
      check("wr_ready", 16'(data_port_wr_ready), 16'h0001);
      check("rd_valid", 16'(data_port_rd_valid), 16'h0000);
      put_run(16'hB712, 9);
      check("wr_ready full", 16'(data_port_wr_ready), 16'h0000);
      master_mode <= 1'b1;
      tx_empty_dma_en <= 1'b1;
      port_enable <= 1'b1;
      await(0);
      await(1);
      check("peer count", 16'(serial_peer_model_inst.got_q.size()), 16'h0008);
      for (int i = 0; i < 8; i++)
         check("peer rx", serial_peer_model_inst.got_q[i],
               {8'h00, 8'(16'hB712 + 16'(i) * 16'h0111)});
      rx_avail_irq_en <= 1'b1;
      tick(2);
      check("irq", 16'(interrupt_request), 16'h0001);
      for (int i = 0; i < 8; i++)
         pop({8'h00, 8'h5A ^ 8'(i)}, 1'b1);
      tick(2);
      check("timeout clear", 16'(rx_timeout), 16'h0000);
      loopback <= 1'b1;
      for (int f = 0; f < 3; f++)
      begin
         frame_format <= 2'(f);
         put_run(16'h00C0 + 16'(f), 1);
         // Half duplex: the message format hears only the quiet line after its control byte.
         pop((f < 2) ? 16'h00C0 + 16'(f) : 16'h0000, 1'b1);
      end
      // A second reset clears the queue history for the slave checks.
      reset <= 1'b1;
      {master_mode, loopback, port_enable, tx_empty_dma_en} <= 4'h0;
      frame_format <= 2'h0;
      tick(20);
      reset <= 1'b0;
      port_enable <= 1'b1;
      tick(4);
      sframe(8'h00);
      put_run(16'h1E01, 8);
      for (int i = 0; i < 8; i++)
         sframe(8'(16'h1E01 + 16'(i) * 16'h0111));
      sframe(8'h01);
      results();
   end
endmodule

bind sync_serial_port sync_serial_port_checker sync_serial_port_checker_inst (.ref_clk,
   .reset, .port_enable, .master_mode, .frame_format, .clock_polarity, .data_size,
   .prescale_divisor, .clock_rate_field, .tx_empty_irq_en, .tx_empty_dma_en,
   .rx_avail_irq_en, .rx_timeout_irq_en, .data_port_wr_valid, .data_port_wr_ready,
   .data_port_rd_valid, .data_port_rd_data, .serial_clock_out, .serial_clock_oe,
   .frame_select_out, .frame_select_oe, .interrupt_request, .tx_dma_request, .rx_timeout);
`default_nettype wire
